/* File: verilog/ioex_map.vh */
// Constants for the pin and excitation control register bank.
// Assumes inclusion by bare name from the design files of this block only.
`ifndef IOEX_MAP_VH
`define IOEX_MAP_VH

// Register byte offsets on the Avalon-MM slave.
`define IOEX_ADDR_W          4
`define IOEX_OFF_SETUP       4'h0
`define IOEX_OFF_STATUS      4'h4

// Register widths and reset values.
`define IOEX_REG_W           24
`define IOEX_SETUP_RST       24'h00_0000
`define IOEX_BUS_W           32
`define IOEX_BE_W            4
`define IOEX_UPPER_ZERO      8'h00

// Field positions of the setup register.
`define IOEX_BIT_PIN1_VAL    20
`define IOEX_BIT_PIN4_EN     19
`define IOEX_BIT_PIN3_EN     18
`define IOEX_BIT_PIN2_EN     17
`define IOEX_BIT_PIN1_EN     16
`define IOEX_BIT_SWITCH      15
`define IOEX_BIT_ZERO        14
`define IOEX_CUR_B_HI        13
`define IOEX_CUR_B_LO        11
`define IOEX_CUR_A_HI        10
`define IOEX_CUR_A_LO        8

// Field positions of the status register.
`define IOEX_ST_PIN1_LVL     0
`define IOEX_ST_STANDBY      1
`define IOEX_ST_CUR_A_ON     2
`define IOEX_ST_CUR_B_ON     3

// Excitation current codes and magnitudes in tenths of a microamp.
`define IOEX_CODE_W          3
`define IOEX_CODE_OFF        3'h0
`define IOEX_CODE_50U        3'h1
`define IOEX_CODE_100U       3'h2
`define IOEX_CODE_250U       3'h3
`define IOEX_CODE_500U       3'h4
`define IOEX_CODE_750U       3'h5
`define IOEX_CODE_1000U      3'h6
`define IOEX_CODE_100N       3'h7
`define IOEX_TENTHS_W        14
`define IOEX_TENTHS_OFF      14'h0000
`define IOEX_TENTHS_50U      14'h01F4
`define IOEX_TENTHS_100U     14'h03E8
`define IOEX_TENTHS_250U     14'h09C4
`define IOEX_TENTHS_500U     14'h1388
`define IOEX_TENTHS_750U     14'h1D4C
`define IOEX_TENTHS_1000U    14'h2710
`define IOEX_TENTHS_100N     14'h0001

`endif

/* File: verilog/ioex_current_dec.v */
// Holds one excitation current code and decodes it into a magnitude.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ioex_map.vh"

module ioex_current_dec (
    input  wire                        mclk,
    input  wire                        rst,
    input  wire                        clk_en,
    input  wire                        wr_en,
    input  wire [`IOEX_CODE_W-1:0]     wr_code,
    output reg  [`IOEX_CODE_W-1:0]     code_q,
    output reg  [`IOEX_TENTHS_W-1:0]   tenths_q,
    output reg                         on_q
);

    // Maps a code onto its current in tenths of a microamp.
    function [`IOEX_TENTHS_W-1:0] code_to_tenths;
        input [`IOEX_CODE_W-1:0] c;
        begin
            case (c)
                `IOEX_CODE_OFF:   code_to_tenths = `IOEX_TENTHS_OFF;
                `IOEX_CODE_50U:   code_to_tenths = `IOEX_TENTHS_50U;
                `IOEX_CODE_100U:  code_to_tenths = `IOEX_TENTHS_100U;
                `IOEX_CODE_250U:  code_to_tenths = `IOEX_TENTHS_250U;
                `IOEX_CODE_500U:  code_to_tenths = `IOEX_TENTHS_500U;
                `IOEX_CODE_750U:  code_to_tenths = `IOEX_TENTHS_750U;
                `IOEX_CODE_1000U: code_to_tenths = `IOEX_TENTHS_1000U;
                default:          code_to_tenths = `IOEX_TENTHS_100N;
            endcase
        end
    endfunction

    // Stores the code and its decoded magnitude together so both change at one edge.
    always @(posedge mclk) begin
        if (rst) begin
            code_q   <= `IOEX_CODE_OFF;
            tenths_q <= `IOEX_TENTHS_OFF;
            on_q     <= 1'b0;
        end else if (clk_en && wr_en) begin
            code_q   <= wr_code;
            tenths_q <= code_to_tenths(wr_code);
            on_q     <= (wr_code != `IOEX_CODE_OFF);
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ioex_pin_drive.v */
// Drives general output pin 1 and samples its real level back.
// Assumes the pin input arrives from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ioex_map.vh"

module ioex_pin_drive (
    input  wire mclk,
    input  wire rst,
    input  wire clk_en,
    input  wire value,
    input  wire enable,
    input  wire pin_i,
    output reg  pin_o_q,
    output reg  pin_oe_q,
    output reg  level_q
);

    reg meta_q;

    // Output flops; with enable low the pin is released and never driven.
    always @(posedge mclk) begin
        if (rst) begin
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
        end else if (clk_en) begin
            pin_o_q  <= value;
            pin_oe_q <= enable;
        end
    end

    // Two-stage synchroniser; only the second stage is read.
    always @(posedge mclk) begin
        if (rst) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
        end else if (clk_en) begin
            meta_q  <= pin_i;
            level_q <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ioex_top.v */
// Pin and excitation control register bank behind an Avalon-MM slave.
// Assumes one clock, a synchronous reset, and a master that holds its request
// until it samples waitrequest low. The standby input comes from logic on mclk.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ioex_map.vh"

module ioex_top (
    input  wire                         mclk,
    input  wire                         rst,
    input  wire                         clk_en,
    input  wire [`IOEX_ADDR_W-1:0]      avs_address,
    input  wire                         avs_read,
    input  wire                         avs_write,
    input  wire [`IOEX_BUS_W-1:0]       avs_writedata,
    input  wire [`IOEX_BE_W-1:0]        avs_byteenable,
    output reg  [`IOEX_BUS_W-1:0]       avs_readdata,
    output reg                          avs_waitrequest,
    input  wire                         standby,
    input  wire                         general_out_one_i,
    output wire                         general_out_one_o,
    output wire                         general_out_one_oe,
    output reg                          general_out_two_oe,
    output reg                          general_out_three_oe,
    output reg                          general_out_four_oe,
    output reg                          analog_in_two_en,
    output reg                          analog_in_three_en,
    output reg                          analog_in_four_en,
    output reg                          analog_in_five_en,
    output reg                          bridge_switch_close,
    output wire [`IOEX_CODE_W-1:0]      excitation_current_a_code,
    output wire [`IOEX_TENTHS_W-1:0]    excitation_current_a_tenths,
    output wire                         excitation_current_a_on,
    output wire [`IOEX_CODE_W-1:0]      excitation_current_b_code,
    output wire [`IOEX_TENTHS_W-1:0]    excitation_current_b_tenths,
    output wire                         excitation_current_b_on
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////////

    // Stored control bits; the current codes live in the decoder instances.
    reg                           out_pin1_value_q;
    reg                           out_pin1_enable_q;
    reg                           out_pin2_enable_q;
    reg                           out_pin3_enable_q;
    reg                           out_pin4_enable_q;
    reg                           bridge_switch_q;
    reg                           zero_bit_q;

    // Bus handshake state.
    reg                           ack_q;

    // Write path signals.
    wire                          req;
    wire                          take;
    wire                          setup_sel;
    wire                          status_sel;
    wire                          setup_wr;
    wire [`IOEX_REG_W-1:0]        lane_mask;
    wire [`IOEX_REG_W-1:0]        setup_cur;
    reg  [`IOEX_REG_W-1:0]        setup_new;
    wire                          cur_a_wr;
    wire                          cur_b_wr;

    // Read path signals.
    wire                          pin1_level;
    reg  [`IOEX_REG_W-1:0]        setup_rd;
    reg  [`IOEX_REG_W-1:0]        status_rd;
    reg  [`IOEX_BUS_W-1:0]        rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    ////////////////////////////////////////////////////////////////////////////

    // Any pending request; read and write are never high together.
    assign req        = avs_read | avs_write;

    // A request is taken at the edge where waitrequest is sampled low.
    assign take       = req & ~avs_waitrequest;

    // Decodes the two mapped words; other offsets read zero and ignore writes.
    assign setup_sel  = (avs_address == `IOEX_OFF_SETUP);
    assign status_sel = (avs_address == `IOEX_OFF_STATUS);

    // The setup register changes only on the completing edge of a write.
    assign setup_wr   = take & avs_write & setup_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Byte lanes.
    ////////////////////////////////////////////////////////////////////////////

    // Expands each byte enable over its eight bits of the 24-bit register.
    genvar gi;
    generate
        for (gi = 0; gi < `IOEX_REG_W; gi = gi + 1) begin : g_lane
            assign lane_mask[gi] = avs_byteenable[gi / 8];
        end
    endgenerate

    // Current contents gathered at their field positions.
    assign setup_cur = {3'h0,
                        out_pin1_value_q,
                        out_pin4_enable_q,
                        out_pin3_enable_q,
                        out_pin2_enable_q,
                        out_pin1_enable_q,
                        bridge_switch_q,
                        zero_bit_q,
                        excitation_current_b_code,
                        excitation_current_a_code,
                        8'h00};

    // Merges write data into the current contents lane by lane.
    always @* begin
        setup_new = (setup_cur & ~lane_mask)
                  | (avs_writedata[`IOEX_REG_W-1:0] & lane_mask);
    end

    // A current field is rewritten only when its byte lane is enabled.
    assign cur_a_wr = setup_wr & lane_mask[`IOEX_CUR_A_LO];
    assign cur_b_wr = setup_wr & lane_mask[`IOEX_CUR_B_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Control register bits.
    ////////////////////////////////////////////////////////////////////////////

    // Pin data, pin enables, bridge switch and the must-be-zero bit.
    // Bit 14 is stored and read back as written; software keeps it at zero.
    // A data bit keeps its stored value whatever its enable does.
    always @(posedge mclk) begin
        if (rst) begin
            out_pin1_value_q  <= 1'b0;
            out_pin1_enable_q <= 1'b0;
            out_pin2_enable_q <= 1'b0;
            out_pin3_enable_q <= 1'b0;
            out_pin4_enable_q <= 1'b0;
            bridge_switch_q   <= 1'b0;
            zero_bit_q        <= 1'b0;
        end else if (clk_en && setup_wr) begin
            out_pin1_value_q  <= setup_new[`IOEX_BIT_PIN1_VAL];
            out_pin4_enable_q <= setup_new[`IOEX_BIT_PIN4_EN];
            out_pin3_enable_q <= setup_new[`IOEX_BIT_PIN3_EN];
            out_pin2_enable_q <= setup_new[`IOEX_BIT_PIN2_EN];
            out_pin1_enable_q <= setup_new[`IOEX_BIT_PIN1_EN];
            bridge_switch_q   <= setup_new[`IOEX_BIT_SWITCH];
            zero_bit_q        <= setup_new[`IOEX_BIT_ZERO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Excitation current selection.
    ////////////////////////////////////////////////////////////////////////////

    // First source: all eight codes share the second source's table.
    ioex_current_dec u_cur_a (
        .mclk     (mclk),
        .rst      (rst),
        .clk_en   (clk_en),
        .wr_en    (cur_a_wr),
        .wr_code  (setup_new[`IOEX_CUR_A_HI:`IOEX_CUR_A_LO]),
        .code_q   (excitation_current_a_code),
        .tenths_q (excitation_current_a_tenths),
        .on_q     (excitation_current_a_on)
    );

    // Second source with the full eight-code table.
    ioex_current_dec u_cur_b (
        .mclk     (mclk),
        .rst      (rst),
        .clk_en   (clk_en),
        .wr_en    (cur_b_wr),
        .wr_code  (setup_new[`IOEX_CUR_B_HI:`IOEX_CUR_B_LO]),
        .code_q   (excitation_current_b_code),
        .tenths_q (excitation_current_b_tenths),
        .on_q     (excitation_current_b_on)
    );

    ////////////////////////////////////////////////////////////////////////////
    // General output pin 1.
    ////////////////////////////////////////////////////////////////////////////

    // Drives the pin from its data bit and samples the real level back.
    // With the enable low the output enable drops, so the data bit has no effect.
    ioex_pin_drive u_pin1 (
        .mclk     (mclk),
        .rst      (rst),
        .clk_en   (clk_en),
        .value    (out_pin1_value_q),
        .enable   (out_pin1_enable_q),
        .pin_i    (general_out_one_i),
        .pin_o_q  (general_out_one_o),
        .pin_oe_q (general_out_one_oe),
        .level_q  (pin1_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin role outputs.
    ////////////////////////////////////////////////////////////////////////////

    // Each enable turns a pin into an output; cleared, the analog input returns.
    // The bridge switch follows its bit alone, so standby leaves it as set.
    always @(posedge mclk) begin
        if (rst) begin
            general_out_two_oe   <= 1'b0;
            general_out_three_oe <= 1'b0;
            general_out_four_oe  <= 1'b0;
            analog_in_two_en     <= 1'b1;
            analog_in_three_en   <= 1'b1;
            analog_in_four_en    <= 1'b1;
            analog_in_five_en    <= 1'b1;
            bridge_switch_close  <= 1'b0;
        end else if (clk_en) begin
            general_out_two_oe   <= out_pin2_enable_q;
            general_out_three_oe <= out_pin3_enable_q;
            general_out_four_oe  <= out_pin4_enable_q;
            analog_in_two_en     <= ~out_pin1_enable_q;
            analog_in_three_en   <= ~out_pin2_enable_q;
            analog_in_four_en    <= ~out_pin3_enable_q;
            analog_in_five_en    <= ~out_pin4_enable_q;
            bridge_switch_close  <= bridge_switch_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////////////////

    // Setup readback; the pin-1 data bit shows the sampled pin when enabled.
    always @* begin
        setup_rd = setup_cur;
        if (out_pin1_enable_q) begin
            setup_rd[`IOEX_BIT_PIN1_VAL] = pin1_level;
        end
    end

    // Status word: live pin level, standby and which sources are on.
    always @* begin
        status_rd = `IOEX_SETUP_RST;
        status_rd[`IOEX_ST_PIN1_LVL] = pin1_level;
        status_rd[`IOEX_ST_STANDBY]  = standby;
        status_rd[`IOEX_ST_CUR_A_ON] = excitation_current_a_on;
        status_rd[`IOEX_ST_CUR_B_ON] = excitation_current_b_on;
    end

    // Selects the addressed word; unmapped offsets return zero.
    always @* begin
        if (setup_sel) begin
            rd_mux = {`IOEX_UPPER_ZERO, setup_rd};
        end else if (status_sel) begin
            rd_mux = {`IOEX_UPPER_ZERO, status_rd};
        end else begin
            rd_mux = {`IOEX_UPPER_ZERO, `IOEX_SETUP_RST};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM handshake.
    ////////////////////////////////////////////////////////////////////////////

    // Waitrequest idles high. A new request drops it for one cycle, and the
    // read data is captured in that same step, so it stands at the completing
    // edge. After completion one idle high cycle separates requests, which
    // keeps a held request from being answered twice.
    always @(posedge mclk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            ack_q           <= 1'b0;
            avs_readdata    <= {`IOEX_UPPER_ZERO, `IOEX_SETUP_RST};
        end else if (clk_en) begin
            if (take) begin
                avs_waitrequest <= 1'b1;
                ack_q           <= 1'b1;
            end else if (req && !ack_q) begin
                avs_waitrequest <= 1'b0;
                if (avs_read) begin
                    avs_readdata <= rd_mux;
                end
            end else begin
                avs_waitrequest <= 1'b1;
                ack_q           <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: sim/ioex_properties.sv */
// Checker for the pin and excitation control register bank.
// Assumes clk_en stays high and the top module is ioex_top.
`timescale 1ns/1ps
`default_nettype none

module ioex_properties (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic        avs_read,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        standby,
    input wire logic        general_out_one_o,
    input wire logic        general_out_one_oe,
    input wire logic        general_out_two_oe,
    input wire logic        general_out_three_oe,
    input wire logic        general_out_four_oe,
    input wire logic        analog_in_two_en,
    input wire logic        analog_in_three_en,
    input wire logic        analog_in_four_en,
    input wire logic        analog_in_five_en,
    input wire logic        bridge_switch_close,
    input wire logic [2:0]  excitation_current_a_code,
    input wire logic [13:0] excitation_current_a_tenths,
    input wire logic        excitation_current_a_on,
    input wire logic [2:0]  excitation_current_b_code,
    input wire logic [13:0] excitation_current_b_tenths,
    input wire logic        excitation_current_b_on
);
    localparam logic [13:0] TENTHS [0:7] = '{14'h0000, 14'h01F4, 14'h03E8, 14'h09C4,
                                             14'h1388, 14'h1D4C, 14'h2710, 14'h0001};
    logic done_q;

    // A completed write to the setup register.
    assign done_q = avs_write && !avs_waitrequest && (avs_address == 4'h0);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Pin outputs follow the stored bits one edge after the write lands.
    AST_PIN1_VALUE: assert property (done_q && avs_byteenable[2] |=> ##1
        general_out_one_o == $past(avs_writedata[20], 2)) else $error("pin one value wrong");
    AST_PIN1_EN: assert property (done_q && avs_byteenable[2] |=> ##1
        general_out_one_oe == $past(avs_writedata[16], 2) && analog_in_two_en != general_out_one_oe)
        else $error("pin one enable wrong");
    AST_PIN2_EN: assert property (done_q && avs_byteenable[2] |=> ##1
        general_out_two_oe == $past(avs_writedata[17], 2) && analog_in_three_en != general_out_two_oe)
        else $error("pin two enable wrong");
    AST_PIN3_EN: assert property (done_q && avs_byteenable[2] |=> ##1
        general_out_three_oe == $past(avs_writedata[18], 2) && analog_in_four_en != general_out_three_oe)
        else $error("pin three enable wrong");
    AST_PIN4_EN: assert property (done_q && avs_byteenable[2] |=> ##1
        general_out_four_oe == $past(avs_writedata[19], 2) && analog_in_five_en != general_out_four_oe)
        else $error("pin four enable wrong");
    AST_SWITCH: assert property (done_q && avs_byteenable[1] |=> ##1
        bridge_switch_close == $past(avs_writedata[15], 2)) else $error("bridge switch wrong");
    // The switch moves only as the delayed result of a write, never on standby.
    AST_SWITCH_HOLD: assert property ($changed(bridge_switch_close) |->
        $past(done_q && avs_byteenable[1], 2)) else $error("bridge switch moved alone");
    // Current codes decode at the completing edge.
    AST_CUR_B: assert property (done_q && avs_byteenable[1] |=>
        excitation_current_b_code == $past(avs_writedata[13:11])
        && excitation_current_b_on == (excitation_current_b_code != 3'h0)
        && excitation_current_b_tenths == TENTHS[excitation_current_b_code]) else $error("source b wrong");
    AST_CUR_A: assert property (done_q && avs_byteenable[1] |=>
        excitation_current_a_code == $past(avs_writedata[10:8])
        && excitation_current_a_on == (excitation_current_a_code != 3'h0)
        && excitation_current_a_tenths == TENTHS[excitation_current_a_code]) else $error("source a wrong");

    // Main scenarios.
    COV_PIN_WRITE: cover property (done_q && avs_byteenable[2] && avs_writedata[16]);
    COV_READ: cover property (avs_read && !avs_waitrequest);
    COV_STANDBY: cover property (standby && bridge_switch_close);
endmodule

bind ioex_top ioex_properties i_props (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_write(avs_write), .avs_read(avs_read), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .standby(standby),
    .general_out_one_o(general_out_one_o), .general_out_one_oe(general_out_one_oe),
    .general_out_two_oe(general_out_two_oe), .general_out_three_oe(general_out_three_oe),
    .general_out_four_oe(general_out_four_oe), .analog_in_two_en(analog_in_two_en),
    .analog_in_three_en(analog_in_three_en), .analog_in_four_en(analog_in_four_en),
    .analog_in_five_en(analog_in_five_en), .bridge_switch_close(bridge_switch_close),
    .excitation_current_a_code(excitation_current_a_code), .excitation_current_a_tenths(excitation_current_a_tenths),
    .excitation_current_a_on(excitation_current_a_on), .excitation_current_b_code(excitation_current_b_code),
    .excitation_current_b_tenths(excitation_current_b_tenths), .excitation_current_b_on(excitation_current_b_on));
`default_nettype wire

/* File: sim/io_pin_and_excitation_control_tb.sv */
// Self-checking bench for the pin and excitation control register bank.
// Assumes one 10 MHz clock; clk_en is held high throughout.
`timescale 1ns/1ps
`default_nettype none

module io_pin_and_excitation_control_tb;
    logic        mclk, rst, clk_en, avs_read, avs_write, standby, pin_i, waitreq;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, rdata, d;
    logic        o1, oe1, oe2, oe3, oe4, ai2, ai3, ai4, ai5, bridge, on_a, on_b;
    logic [2:0]  code_a, code_b;
    logic [13:0] ten_a, ten_b;
    int          bad_count, n_compared, k;
    logic [13:0] tab [0:7] = '{14'h0000, 14'h01F4, 14'h03E8, 14'h09C4,
                               14'h1388, 14'h1D4C, 14'h2710, 14'h0001};

    ioex_top i_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .standby(standby), .general_out_one_i(pin_i), .general_out_one_o(o1), .general_out_one_oe(oe1),
        .general_out_two_oe(oe2), .general_out_three_oe(oe3), .general_out_four_oe(oe4),
        .analog_in_two_en(ai2), .analog_in_three_en(ai3), .analog_in_four_en(ai4), .analog_in_five_en(ai5),
        .bridge_switch_close(bridge), .excitation_current_a_code(code_a), .excitation_current_a_tenths(ten_a),
        .excitation_current_a_on(on_a), .excitation_current_b_code(code_b),
        .excitation_current_b_tenths(ten_b), .excitation_current_b_on(on_b));

    // Clock of 100 ns period.
    always #50 mclk = ~mclk;

    // Packs the pin control outputs: enables high, analog selects in the middle.
    function automatic logic [31:0] pins();
        return {23'h00_0000, oe4, oe3, oe2, oe1, ai5, ai4, ai3, ai2, bridge};
    endfunction

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        @(posedge mclk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (waitreq === 1'b0) break;
        end
        rd = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 20) begin
            bad_count++;
            conclude();
        end
    endtask

    // Lets the output registers of the completing write land.
    task automatic settle();
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic pad(input logic v);
        @(posedge mclk);
        pin_i <= v;
        repeat (3) @(posedge mclk);
    endtask

    task automatic s_reset();
        @(negedge mclk);
        chk(pins(), 32'h0000_001E);
        chk({24'h00_0000, on_b, on_a, code_b, code_a}, 32'h0000_0000);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0000_0000);
    endtask

    task automatic s_enables();
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 4'h0, 32'h0001_0000 << k, 4'h4, d);
            settle();
            chk(pins(), 32'h0000_001E ^ (32'h0000_0022 << k));
        end
    endtask

    task automatic s_pin1();
        bus(1'b1, 4'h0, 32'h0011_0000, 4'h4, d);
        settle();
        chk({30'h0000_0000, oe1, o1}, 32'h0000_0003);
        pad(1'b0);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0001_0000);
        bus(1'b1, 4'h0, 32'h0001_0000, 4'h4, d);
        settle();
        chk({30'h0000_0000, oe1, o1}, 32'h0000_0002);
        pad(1'b1);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0011_0000);
        bus(1'b1, 4'h0, 32'h0010_0000, 4'h4, d);
        settle();
        chk({30'h0000_0000, oe1, ai2}, 32'h0000_0001);
        pad(1'b0);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0010_0000);
    endtask

    task automatic s_switch();
        bus(1'b1, 4'h0, 32'h0000_8000, 4'h2, d);
        settle();
        chk({31'h0000_0000, bridge}, 32'h0000_0001);
        @(posedge mclk);
        standby <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b0, 4'h4, 32'h0000_0000, 4'hF, d);
        chk({30'h0000_0000, d[1], bridge}, 32'h0000_0003);
        bus(1'b1, 4'h0, 32'h0000_0000, 4'h2, d);
        settle();
        chk({31'h0000_0000, bridge}, 32'h0000_0000);
        @(posedge mclk);
        standby <= 1'b0;
    endtask

    // Every code on both sources, bit 14 kept at zero.
    task automatic s_currents();
        for (k = 0; k < 8; k++) begin
            bus(1'b1, 4'h0, {17'h0_0000, 1'b0, k[2:0], 3'h7 - k[2:0], 8'h00}, 4'h2, d);
            @(negedge mclk);
            chk({14'h0000, on_b, code_b, ten_b}, {14'h0000, k != 0, k[2:0], tab[k]});
            chk({14'h0000, on_a, code_a, ten_a}, {14'h0000, k != 7, 3'h7 - k[2:0], tab[7 - k]});
        end
    endtask

    task automatic s_refuse();
        bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF, d);
        bus(1'b0, 4'h8, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'h9, d);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, d);
        chk(d, 32'h0010_3800);
    endtask

    // Main sequence with reset held for four cycles.
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        {avs_read, avs_write, standby, pin_i} = 4'h0;
        avs_address = 4'h0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0000_0000;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        s_reset();
        s_enables();
        s_pin1();
        s_switch();
        s_currents();
        s_refuse();
        conclude();
    end
endmodule
`default_nettype wire
